// ---- include/flash_status_defs.vh ----
// Constants for the flash status / write-permit block: opcodes, bit places, reset values, timing.
// Assumes it is included by bare name from the rtl files.
`ifndef FLASH_STATUS_DEFS_VH
`define FLASH_STATUS_DEFS_VH

// Status byte bit positions
`define BIT_BUSY              0
`define BIT_WPERMIT           1
`define BIT_PLEVEL_LO         2
`define BIT_PLEVEL_HI         5
`define BIT_FOURLANE          6
`define BIT_SLOCK             7
`define STATUS_RESET          8'h00
`define PROT_RESET            6'h00

// Pin sampler reset image {holdRst_n, wp_n, si, cs_n, sck}
`define PIN_IDLE              5'h1A

// Timing of an internal write cycle
`define CLK_PERIOD_NS         10
`define OP_TIME_NS            10000
`define OP_CYCLES             ((`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Opcodes handled directly by this block
`define CMD_READ_STATUS       8'h05
`define CMD_WRITE_STATUS      8'h01
`define CMD_WRITE_PERMIT      8'h06
`define CMD_WRITE_REVOKE      8'h04
`define CMD_VOL_STATUS_ARM    8'h50
`define CMD_READ_FUNC         8'h48
`define CMD_READ_EXT_PARAMS   8'h81
`define CMD_RESET_ARM         8'h66
`define CMD_RESET_GO          8'h99
`define CMD_SUSPEND           8'h75
`define CMD_RESUME            8'h7A

// Program and erase
`define CMD_PAGE_PROG         8'h02
`define CMD_PAGE_PROG_WIDE    8'h12
`define CMD_PAGE_PROG_4L_A    8'h32
`define CMD_PAGE_PROG_4L_B    8'h38
`define CMD_PAGE_PROG_4LW_A   8'h34
`define CMD_PAGE_PROG_4LW_B   8'h3E
`define CMD_SECT_ERASE_A      8'hD7
`define CMD_SECT_ERASE_B      8'h20
`define CMD_SECT_ERASE_WIDE   8'h21
`define CMD_BLK32_ERASE       8'h52
`define CMD_BLK32_ERASE_WIDE  8'h5C
`define CMD_BLK64_ERASE       8'hD8
`define CMD_BLK64_ERASE_WIDE  8'hDC
`define CMD_ARRAY_ERASE_A     8'hC7
`define CMD_ARRAY_ERASE_B     8'h60

// Persistent configuration writes (start a busy cycle)
`define CMD_FUNC_WRITE        8'h42
`define CMD_RDPAR_NV_WRITE    8'h65
`define CMD_XRDPAR_NV_WRITE   8'h85
`define CMD_INFO_ERASE        8'h64
`define CMD_INFO_PROG         8'h62
`define CMD_BOOT_WRITE        8'h15
`define CMD_BANK_NV_WRITE     8'h18
`define CMD_PPROT_WRITE_A     8'hFD
`define CMD_PPROT_WRITE_B     8'hE3
`define CMD_PPROT_ERASE       8'hE4
`define CMD_ASP_PROG          8'h2F
`define CMD_PPROT_LOCK        8'hA6
`define CMD_FREEZE            8'h91
`define CMD_GANG_LOCK         8'h7E
`define CMD_GANG_UNLOCK       8'h98
`define CMD_PASSWORD_PROG     8'hE8
`define CMD_LEARN_NV_PROG     8'h43
`define CMD_ECC_WRITE         8'hB5

// Volatile configuration writes (need the permit latch, no busy cycle)
`define CMD_RDPAR_V_WRITE     8'h63
`define CMD_XRDPAR_V_WRITE    8'h83
`define CMD_BANK_V_WRITE      8'hC5
`define CMD_DPROT_WRITE_A     8'hFB
`define CMD_DPROT_WRITE_B     8'hE1
`define CMD_LEARN_V_PROG      8'h4A

`endif

// ---- rtl/cmd_class.v ----
// Opcode classifier for the status / write-permit block.
// Assumes a registered opcode at its input; purely combinational.
`timescale 1ns/1ps
`include "flash_status_defs.vh"
module cmd_class (
    // Opcode in
    input  wire [7:0] opcode,
    // Class flags out
    output reg        needsPermit,
    output reg        startsCycle,
    output reg        okWhileBusy,
    output reg        isArrayErase
);
    always @*
    begin
        needsPermit  = 1'b0;
        startsCycle  = 1'b0;
        okWhileBusy  = 1'b0;
        isArrayErase = 1'b0;
        case (opcode)
            `CMD_PAGE_PROG, `CMD_PAGE_PROG_WIDE, `CMD_PAGE_PROG_4L_A, `CMD_PAGE_PROG_4L_B,
            `CMD_PAGE_PROG_4LW_A, `CMD_PAGE_PROG_4LW_B:
            begin
                needsPermit = 1'b1;
                startsCycle = 1'b1;
            end
            `CMD_SECT_ERASE_A, `CMD_SECT_ERASE_B, `CMD_SECT_ERASE_WIDE, `CMD_BLK32_ERASE,
            `CMD_BLK32_ERASE_WIDE, `CMD_BLK64_ERASE, `CMD_BLK64_ERASE_WIDE:
            begin
                needsPermit = 1'b1;
                startsCycle = 1'b1;
            end
            `CMD_ARRAY_ERASE_A, `CMD_ARRAY_ERASE_B:
            begin
                needsPermit  = 1'b1;
                startsCycle  = 1'b1;
                isArrayErase = 1'b1;
            end
            `CMD_FUNC_WRITE, `CMD_RDPAR_NV_WRITE, `CMD_XRDPAR_NV_WRITE, `CMD_INFO_ERASE,
            `CMD_INFO_PROG, `CMD_BOOT_WRITE, `CMD_BANK_NV_WRITE, `CMD_PPROT_WRITE_A,
            `CMD_PPROT_WRITE_B, `CMD_PPROT_ERASE, `CMD_ASP_PROG, `CMD_PPROT_LOCK, `CMD_FREEZE,
            `CMD_GANG_LOCK, `CMD_GANG_UNLOCK, `CMD_PASSWORD_PROG, `CMD_LEARN_NV_PROG,
            `CMD_ECC_WRITE:
            begin
                needsPermit = 1'b1;
                startsCycle = 1'b1;
            end
            `CMD_RDPAR_V_WRITE, `CMD_XRDPAR_V_WRITE, `CMD_BANK_V_WRITE, `CMD_DPROT_WRITE_A,
            `CMD_DPROT_WRITE_B, `CMD_LEARN_V_PROG:
                needsPermit = 1'b1;
            `CMD_READ_STATUS, `CMD_READ_FUNC, `CMD_READ_EXT_PARAMS, `CMD_RESET_ARM,
            `CMD_RESET_GO, `CMD_SUSPEND:
                okWhileBusy = 1'b1;
            default:
                needsPermit = 1'b0;
        endcase
    end
endmodule

// ---- rtl/flash_status_write_enable.v ----
// Status byte and write-permit latch of a serial flash, with a single-lane serial front end.
// Assumes pins arrive asynchronously; sck is far slower than clk (several clk per half period).
`timescale 1ns/1ps
`include "flash_status_defs.vh"
module flash_status_write_enable #(
    parameter [15:0] OP_CYCLES = `OP_CYCLES
)(
    // Clock and reset
    input  wire       clk,
    input  wire       arst_n,
    // Serial pins
    input  wire       sckPin,
    input  wire       csPin_n,
    input  wire       siPin,
    output wire       soPin,
    output wire       soOe_n,
    // Control pins
    input  wire       wpPin_n,
    input  wire       holdRstPin_n,
    // Status to the rest of the device
    output wire       fourLaneMode,
    output wire       busy,
    output wire       cmdStrobe,
    output wire [7:0] cmdCode
);
    // Pin sampling
    wire [4:0] pinsRaw;
    wire [4:0] pinsF;
    reg  [4:0] pinsPrev_q;

    assign pinsRaw = {holdRstPin_n, wpPin_n, siPin, csPin_n, sckPin};

    pin_sync3 #(
        .WIDTH (5),
        .INIT  (`PIN_IDLE)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .din    (pinsRaw),
        .dout   (pinsF)
    );

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pinsPrev_q <= `PIN_IDLE;
        else
            pinsPrev_q <= pinsF;
    end

    wire sckRise;
    wire sckFall;
    wire csLow;
    wire csFall;
    wire csRise;
    assign sckRise = pinsF[0] & ~pinsPrev_q[0];
    assign sckFall = ~pinsF[0] & pinsPrev_q[0];
    assign csLow   = ~pinsF[1];
    assign csFall  = ~pinsF[1] & pinsPrev_q[1];
    assign csRise  = pinsF[1] & ~pinsPrev_q[1];

    // Stored state
    reg  [5:0]  volProt_q;
    reg  [5:0]  nvProt_q;
    reg         permit_q;
    reg         busy_q;
    reg         susp_q;
    reg  [15:0] cycCnt_q;
    reg         volArm_q;
    reg         rstArm_q;
    reg         loadPend_q;
    reg         cmdStrobe_q;
    reg  [7:0]  cmdCode_q;

    // Volatile copy only is visible to reads
    wire [7:0] statusRead;
    assign statusRead = {volProt_q, permit_q, busy_q};

    // Control pins lose their function in four-lane mode
    wire quad;
    wire hwReset;
    wire statusLocked;
    assign quad         = volProt_q[`BIT_FOURLANE - 2];
    assign hwReset      = ~quad & ~pinsF[4];
    assign statusLocked = volProt_q[`BIT_SLOCK - 2] & ~quad & ~pinsF[3];

    // Serial frame capture
    reg  [4:0] bitCnt_q;
    reg  [7:0] shift_q;
    reg  [7:0] opcode_q;
    reg  [7:0] data_q;
    reg        haveOp_q;
    reg        haveData_q;
    wire [7:0] shiftNext;
    assign shiftNext = {shift_q[6:0], pinsF[2]};

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bitCnt_q   <= 5'h00;
            shift_q    <= 8'h00;
            opcode_q   <= 8'h00;
            data_q     <= 8'h00;
            haveOp_q   <= 1'b0;
            haveData_q <= 1'b0;
        end
        else if (csFall)
        begin
            bitCnt_q   <= 5'h00;
            haveOp_q   <= 1'b0;
            haveData_q <= 1'b0;
        end
        else if (sckRise && csLow)
        begin
            shift_q <= shiftNext;
            if (bitCnt_q != 5'h1F)
                bitCnt_q <= bitCnt_q + 5'h01;
            if (bitCnt_q == 5'h07)
            begin
                opcode_q <= shiftNext;
                haveOp_q <= 1'b1;
            end
            if (bitCnt_q == 5'h0F)
            begin
                data_q     <= shiftNext;
                haveData_q <= 1'b1;
            end
        end
    end

    // Serial status output, snapshot per byte so a byte never tears mid-shift
    reg  [2:0] outIdx_q;
    reg  [7:0] snap_q;
    reg        soPin_q;
    reg        soOe_n_q;
    wire       readingStatus;
    assign readingStatus = haveOp_q && (opcode_q == `CMD_READ_STATUS);

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            outIdx_q <= 3'h0;
            snap_q   <= `STATUS_RESET;
            soPin_q  <= 1'b0;
            soOe_n_q <= 1'b1;
        end
        else if (!csLow)
        begin
            outIdx_q <= 3'h0;
            soOe_n_q <= 1'b1;
        end
        else if (sckFall && readingStatus)
        begin
            soOe_n_q <= 1'b0;
            outIdx_q <= outIdx_q + 3'h1;
            if (outIdx_q == 3'h0)
            begin
                snap_q  <= statusRead;
                soPin_q <= statusRead[7];
            end
            else
                soPin_q <= snap_q[3'h7 - outIdx_q];
        end
    end

    // Command classes
    wire needsPermit;
    wire startsCycle;
    wire okWhileBusy;
    wire isArrayErase;

    cmd_class u_class (
        .opcode       (opcode_q),
        .needsPermit  (needsPermit),
        .startsCycle  (startsCycle),
        .okWhileBusy  (okWhileBusy),
        .isArrayErase (isArrayErase)
    );

    wire frameEnd;
    wire accepted;
    wire isWriteStatus;
    wire protZero;
    wire permitOk;
    assign frameEnd      = csRise & haveOp_q;
    assign accepted      = frameEnd & (~busy_q | okWhileBusy);
    assign isWriteStatus = (opcode_q == `CMD_WRITE_STATUS);
    assign protZero      = (volProt_q[3:0] == 4'h0);
    // Array erase is refused while any protection level bit (status bits 2 to 5) is set
    assign permitOk      = permit_q & ~(isArrayErase & ~protZero);

    // Status, latch and busy cycle
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            volProt_q   <= `PROT_RESET;
            nvProt_q    <= `PROT_RESET;
            permit_q    <= 1'b0;
            busy_q      <= 1'b0;
            susp_q      <= 1'b0;
            cycCnt_q    <= 16'h0000;
            volArm_q    <= 1'b0;
            rstArm_q    <= 1'b0;
            loadPend_q  <= 1'b1;
            cmdStrobe_q <= 1'b0;
            cmdCode_q   <= 8'h00;
        end
        else
        begin
            cmdStrobe_q <= 1'b0;
            if (loadPend_q)
            begin
                volProt_q  <= nvProt_q;
                loadPend_q <= 1'b0;
            end
            else if (hwReset || (accepted && opcode_q == `CMD_RESET_GO && rstArm_q))
            begin
                // Reset aborts any cycle and reloads from the persistent copy
                volProt_q <= nvProt_q;
                permit_q  <= 1'b0;
                busy_q    <= 1'b0;
                susp_q    <= 1'b0;
                cycCnt_q  <= 16'h0000;
                volArm_q  <= 1'b0;
                rstArm_q  <= 1'b0;
            end
            else
            begin
                if (busy_q)
                begin
                    cycCnt_q <= cycCnt_q - 16'h0001;
                    if (cycCnt_q == 16'h0001)
                    begin
                        busy_q   <= 1'b0;
                        permit_q <= 1'b0;
                    end
                end
                if (accepted)
                begin
                    cmdCode_q <= opcode_q;
                    // Arm lasts for exactly the next command only
                    volArm_q  <= (opcode_q == `CMD_VOL_STATUS_ARM);
                    rstArm_q  <= (opcode_q == `CMD_RESET_ARM);
                    if (opcode_q == `CMD_WRITE_PERMIT)
                    begin
                        permit_q    <= 1'b1;
                        cmdStrobe_q <= 1'b1;
                    end
                    else if (opcode_q == `CMD_WRITE_REVOKE)
                    begin
                        permit_q    <= 1'b0;
                        cmdStrobe_q <= 1'b1;
                    end
                    else if (opcode_q == `CMD_SUSPEND)
                    begin
                        // A cycle in its last clock just ends; a resume would meet a wrapped count
                        if (busy_q && !susp_q && cycCnt_q != 16'h0001)
                        begin
                            busy_q      <= 1'b0;
                            susp_q      <= 1'b1;
                            cmdStrobe_q <= 1'b1;
                        end
                    end
                    else if (opcode_q == `CMD_RESUME)
                    begin
                        if (susp_q)
                        begin
                            busy_q      <= 1'b1;
                            susp_q      <= 1'b0;
                            cmdStrobe_q <= 1'b1;
                        end
                    end
                    else if (isWriteStatus)
                    begin
                        // Bits 1 and 0 of the data byte are dropped
                        if (haveData_q && !statusLocked)
                        begin
                            if (volArm_q)
                            begin
                                volProt_q   <= data_q[7:2];
                                cmdStrobe_q <= 1'b1;
                            end
                            else if (permit_q)
                            begin
                                volProt_q   <= data_q[7:2];
                                nvProt_q    <= data_q[7:2];
                                busy_q      <= 1'b1;
                                cycCnt_q    <= OP_CYCLES;
                                cmdStrobe_q <= 1'b1;
                            end
                        end
                    end
                    else if (needsPermit)
                    begin
                        if (permitOk && !susp_q)
                        begin
                            cmdStrobe_q <= 1'b1;
                            if (startsCycle)
                            begin
                                busy_q   <= 1'b1;
                                cycCnt_q <= OP_CYCLES;
                            end
                        end
                    end
                    else
                        cmdStrobe_q <= 1'b1;
                end
            end
        end
    end

    // Outputs
    assign soPin        = soPin_q;
    assign soOe_n       = soOe_n_q;
    assign fourLaneMode = volProt_q[`BIT_FOURLANE - 2];
    assign busy         = busy_q;
    assign cmdStrobe    = cmdStrobe_q;
    assign cmdCode      = cmdCode_q;
endmodule

// ---- rtl/pin_sync3.v ----
// Three-stage sampler for pins from outside the clk domain, one lane per bit.
// Assumes asynchronous pins; output changes only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync3 #(
    parameter             WIDTH = 5,
    parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
)(
    // Clock and reset
    input  wire             clk,
    input  wire             arst_n,
    // Pins in, filtered levels out
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : lane
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg out_q;
            // Stage one feeds stage two only, to keep metastability contained
            always @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    s1_q  <= INIT[i];
                    s2_q  <= INIT[i];
                    s3_q  <= INIT[i];
                    out_q <= INIT[i];
                end
                else
                begin
                    s1_q <= din[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q)
                        out_q <= s3_q;
                end
            end
            assign dout[i] = out_q;
        end
    endgenerate
endmodule

// ---- sim/flash_status_chk.sv ----
// Assertions on the ports of the status / write-permit block.
// Assumes a bind into the top module; everything sits in the clk domain.
`timescale 1ns/1ps
module flash_status_chk #(
    parameter [15:0] OP_CYCLES = 16'h03E8
)(
    // Clock and reset
    input wire       clk,
    input wire       arst_n,
    // Serial pins
    input wire       sckPin,
    input wire       csPin_n,
    input wire       siPin,
    input wire       soPin,
    input wire       soOe_n,
    // Control pins
    input wire       wpPin_n,
    input wire       holdRstPin_n,
    // Status outputs
    input wire       fourLaneMode,
    input wire       busy,
    input wire       cmdStrobe,
    input wire [7:0] cmdCode
);
    reg [15:0] runCnt_q;
    // Consecutive busy cycles; suspend restarts it, so resume stays in bound
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            runCnt_q <= 16'h0000;
        else if (busy)
            runCnt_q <= runCnt_q + 16'h0001;
        else
            runCnt_q <= 16'h0000;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_busy_start; $rose(busy); endsequence
    sequence s_deselected; csPin_n [*8]; endsequence
    property p_busy_start;
        s_busy_start |-> cmdStrobe && !(cmdCode inside {8'h04, 8'h05, 8'h06, 8'h50});
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("busy rose without a write");
    property p_busy_max; busy |-> runCnt_q <= OP_CYCLES; endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy held too long");
    property p_while_busy;
        $past(busy) && cmdStrobe |-> cmdCode inside {8'h05, 8'h48, 8'h81, 8'h66, 8'h99, 8'h75};
    endproperty
    a_while_busy: assert property (p_while_busy) else $error("command taken while busy");
    property p_strobe_pulse; cmdStrobe |=> !cmdStrobe; endproperty
    a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe longer than one");
    // Refused frames still move the code, but never with a busy cycle behind them
    property p_code_hold; $changed(cmdCode) && !cmdStrobe |-> !busy; endproperty
    a_code_hold: assert property (p_code_hold) else $error("code moved without strobe");
    property p_so_idle; s_deselected |-> soOe_n; endproperty
    a_so_idle: assert property (p_so_idle) else $error("output driven while deselected");
    property p_four_lane;
        // Software reset gives no strobe and leaves its arming opcode as the last code
        $fell(fourLaneMode) |-> (cmdStrobe && cmdCode == 8'h01) || (!cmdStrobe && cmdCode == 8'h66);
    endproperty
    a_four_lane: assert property (p_four_lane) else $error("four-lane bit dropped");
    property p_reset_vals; $rose(arst_n) |-> !busy && !cmdStrobe && !fourLaneMode; endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad state after reset");
endmodule
bind flash_status_write_enable flash_status_chk #(.OP_CYCLES(OP_CYCLES)) chk (
    .clk(clk), .arst_n(arst_n), .sckPin(sckPin), .csPin_n(csPin_n), .siPin(siPin),
    .soPin(soPin), .soOe_n(soOe_n), .wpPin_n(wpPin_n), .holdRstPin_n(holdRstPin_n),
    .fourLaneMode(fourLaneMode), .busy(busy), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode));

// ---- sim/host_model.sv ----
// Host serial controller model, mode 0, MSB first, one data lane.
// Assumes the bench clk; every pin change lands on a falling clk edge.
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire       clk,
    // Serial pins
    output reg        sckPin,
    output reg        csPin_n,
    output reg        siPin,
    input  wire       soPin,
    input  wire       soOe_n,
    // Read result
    output reg  [7:0] rdByte,
    output reg        rdDone
);
    // Serial clock stands still low between frames
    initial
    begin
        sckPin = 1'b0;
        csPin_n = 1'b1;
        siPin = 1'b0;
        rdByte = 8'h00;
        rdDone = 1'b0;
    end
    task half;
    begin
        repeat (8) @(negedge clk);
    end
    endtask
    task xfer(input [7:0] op, input [7:0] dat, input integer nb);
        reg [15:0] sh;
        integer    i;
    begin
        sh = {op, dat};
        csPin_n <= 1'b0;
        half;
        for (i = 0; i < nb; i = i + 1)
        begin
            siPin <= sh[15-i];
            half;
            sckPin <= 1'b1;
            // An undriven output must never pass for data
            if (i > 7)
                rdByte[15-i] = soOe_n ? 1'bx : soPin;
            half;
            sckPin <= 1'b0;
        end
        half;
        csPin_n <= 1'b1;
        siPin <= ~siPin;
        half;
        if (op == 8'h05)
            rdDone <= 1'b1;
        @(negedge clk);
        rdDone <= 1'b0;
        half;
    end
    endtask
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the status / write-permit block.
// Assumes host_model drives the serial pins and the checker is bound in.
`timescale 1ns/1ps
module testbench;
    reg        clk;
    reg        arst_n;
    reg        wpPin_n;
    reg        holdRstPin_n;
    wire       sckPin, csPin_n, siPin, soPin, soOe_n, fourLaneMode, busy, cmdStrobe, rdDone;
    wire [7:0] cmdCode;
    wire [7:0] rdByte;
    reg  [7:0] stQ[$];
    reg  [7:0] cdQ[$];
    reg  [7:0] d;
    reg  [7:0] ops [0:15];
    integer    n_errors, checked, cycles, i;
    host_model HOST (.clk(clk), .sckPin(sckPin), .csPin_n(csPin_n), .siPin(siPin),
        .soPin(soPin), .soOe_n(soOe_n), .rdByte(rdByte), .rdDone(rdDone));
    // Short busy time keeps the run small; still longer than one read frame
    flash_status_write_enable #(.OP_CYCLES(16'h0258)) DUT (.clk(clk), .arst_n(arst_n),
        .sckPin(sckPin), .csPin_n(csPin_n), .siPin(siPin), .soPin(soPin), .soOe_n(soOe_n),
        .wpPin_n(wpPin_n), .holdRstPin_n(holdRstPin_n), .fourLaneMode(fourLaneMode),
        .busy(busy), .cmdStrobe(cmdStrobe), .cmdCode(cmdCode));
    task test_done;
    begin
        $display("Errors %0d, checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    task cmp_status(input [7:0] e, input [7:0] g);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("Error at %0t: status exp %h got %h", $time, e, g);
        end
    end
    endtask
    task cmp_code(input [7:0] e, input [7:0] g);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("Error at %0t: code exp %h got %h", $time, e, g);
        end
    end
    endtask
    task cmp_flag(input e, input g);
    begin
        checked = checked + 1;
        if (g !== e)
        begin
            n_errors = n_errors + 1;
            $display("Error at %0t: flag exp %h got %h", $time, e, g);
        end
    end
    endtask
    task cmd(input [7:0] op, input [7:0] dat, input integer nb, input ok);
    begin
        if (ok)
            cdQ.push_back(op);
        HOST.xfer(op, dat, nb);
    end
    endtask
    task rd(input [7:0] e);
    begin
        cdQ.push_back(8'h05);
        stQ.push_back(e);
        HOST.xfer(8'h05, 8'h00, 16);
    end
    endtask
    task wait_idle;
        integer k;
    begin
        for (k = 0; k < 1000 && busy !== 1'b0; k = k + 1)
            @(negedge clk);
        cmp_flag(1'b0, busy);
    end
    endtask
    task hold_pulse;
    begin
        holdRstPin_n <= 1'b0;
        repeat (10) @(negedge clk);
        holdRstPin_n <= 1'b1;
        repeat (10) @(negedge clk);
    end
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Strobe with nothing noted is a mismatch against an unknown code
    always @(negedge clk)
    begin
        cycles = cycles + 1;
        if (cmdStrobe !== 1'b0)
            cmp_code(cdQ.size() ? cdQ.pop_front() : 8'hXX, cmdCode);
        if (rdDone === 1'b1 && stQ.size() > 0)
            cmp_status(stQ.pop_front(), rdByte);
        if (cycles == 60000)
        begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
    initial
    begin
        n_errors = 0;
        checked = 0;
        cycles = 0;
        arst_n = 1'b0;
        wpPin_n = 1'b1;
        holdRstPin_n = 1'b1;
        ops = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, 8'hD7, 8'h20, 8'h21, 8'h52,
                8'h5C, 8'hD8, 8'hDC, 8'h42, 8'h65, 8'h85};
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        d = $urandom(81);
        d = $urandom;
        d = (d & 8'h3F) | 8'h04;
        rd(8'h00);
        cmd(8'h01, d, 16, 1'b0);
        rd(8'h00);
        cmd(8'h06, 8'h00, 8, 1'b1);
        rd(8'h02);
        cmd(8'h04, 8'h00, 8, 1'b1);
        rd(8'h00);
        cmd(8'h06, 8'h00, 8, 1'b1);
        cmd(8'h01, d, 16, 1'b1);
        cmp_flag(1'b1, busy);
        cmd(8'h06, 8'h00, 8, 1'b0);
        rd((d & 8'hFC) | 8'h03);
        wait_idle;
        rd(d & 8'hFC);
        cmd(8'h06, 8'h00, 8, 1'b1);
        cmd(8'h50, 8'h00, 8, 1'b1);
        cmd(8'h01, 8'h28, 16, 1'b1);
        cmp_flag(1'b0, busy);
        rd(8'h2A);
        hold_pulse;
        rd(d & 8'hFC);
        cmd(8'h06, 8'h00, 8, 1'b1);
        cmd(8'hC7, 8'h00, 8, 1'b0);
        rd((d & 8'hFC) | 8'h02);
        cmd(8'h04, 8'h00, 8, 1'b1);
        for (i = 0; i < 16; i = i + 1)
        begin
            cmd(ops[i], 8'h00, 8, 1'b0);
            cmd(8'h06, 8'h00, 8, 1'b1);
            cmd(ops[i], 8'h00, 8, 1'b1);
            cmp_flag(1'b1, busy);
            wait_idle;
        end
        rd(d & 8'hFC);
        cmd(8'h06, 8'h00, 8, 1'b1);
        cmd(8'h01, d | 8'h80, 16, 1'b1);
        wait_idle;
        wpPin_n <= 1'b0;
        cmd(8'h06, 8'h00, 8, 1'b1);
        cmd(8'h01, 8'h00, 16, 1'b0);
        rd((d & 8'hFC) | 8'h82);
        wpPin_n <= 1'b1;
        cmd(8'h01, 8'h00, 16, 1'b1);
        wait_idle;
        rd(8'h00);
        cmd(8'h06, 8'h00, 8, 1'b1);
        cmd(8'hC7, 8'h00, 8, 1'b1);
        wait_idle;
        cmd(8'h50, 8'h00, 8, 1'b1);
        cmd(8'h01, 8'h40, 16, 1'b1);
        cmp_flag(1'b1, fourLaneMode);
        hold_pulse;
        cmp_flag(1'b1, fourLaneMode);
        cmd(8'h50, 8'h00, 8, 1'b1);
        cmd(8'h01, 8'h00, 16, 1'b1);
        cmp_flag(1'b0, fourLaneMode);
        cmd(8'h50, 8'h00, 8, 1'b1);
        cmd(8'h01, 8'h40, 16, 1'b1);
        cmd(8'h66, 8'h00, 8, 1'b1);
        cmd(8'h99, 8'h00, 8, 1'b0);
        cmp_flag(1'b0, fourLaneMode);
        repeat (20) @(negedge clk);
        cmp_flag(1'b1, cdQ.size() == 0 && stQ.size() == 0);
        test_done;
    end
endmodule
